// ### scirq_regs.svh
// register map, field positions and reset values of the card select block
`ifndef SCIRQ_REGS_SVH
`define SCIRQ_REGS_SVH

// register indices as printed; byte address is four times the index
`define SCIRQ_IDX_SELECT       16'hFE00
`define SCIRQ_IDX_CAUSE        16'hFE01
`define SCIRQ_IDX_ENABLE       16'hFE02
`define SCIRQ_IDX_INT_LINE     16'hFE10
`define SCIRQ_IDX_EXT_LINE     16'hFE11
`define SCIRQ_IDX_TX_CTRL      16'hFE12
`define SCIRQ_IDX_RX_CTRL      16'hFE13

// apb byte addresses derived from the indices
`define SCIRQ_ADDR_W           18
`define SCIRQ_BYTE(idx)        ({(idx), 2'b00})

// select register fields
`define SCIRQ_SEL_BYPASS       1
`define SCIRQ_SEL_IFACE_LO     2
`define SCIRQ_SEL_IFACE_HI     3
`define SCIRQ_SEL_RESET        8'h00
`define SCIRQ_SEL_WMASK        8'h0E

// cause and enable bit positions (same for both registers)
`define SCIRQ_B_WAIT_TO        7
`define SCIRQ_B_CARD_EVT       6
`define SCIRQ_B_SUPPLY_TMR     5
`define SCIRQ_B_RX_AVAIL       4
`define SCIRQ_B_TX_EVT         3
`define SCIRQ_B_TX_SENT        2
`define SCIRQ_B_TX_ERR         1
`define SCIRQ_B_RX_ERR         0
`define SCIRQ_CAUSE_RESET      8'h00
`define SCIRQ_ENABLE_RESET     8'h00

// line control register fields
`define SCIRQ_LINE_DATA        0
`define SCIRQ_LINE_DIR         1
`define SCIRQ_LINE_STATE       5
`define SCIRQ_LINE_WMASK       8'h03
`define SCIRQ_LINE_RESET       8'h01

// transmit and receive status fields
`define SCIRQ_TX_EMPTY         0
`define SCIRQ_TX_FULL          1
`define SCIRQ_TX_BREAK         2
`define SCIRQ_TX_UNDERRUN      3
`define SCIRQ_RX_OVERRUN       0
`define SCIRQ_RX_PARITY        1

`endif

// ### scirq_pkg.sv
// types shared by the card select and interrupt block
package scirq_pkg;

	// routing choice of the shared uart
	typedef enum logic [1:0] {
		SCIRQ_IF_NONE = 2'b00,
		SCIRQ_IF_EXT  = 2'b01,
		SCIRQ_IF_INT  = 2'b10,
		SCIRQ_IF_INT2 = 2'b11
	} scirq_iface_type;

	typedef logic [7:0] scirq_byte_type;

endpackage

// ### scirq_flag.sv
// sticky status flag where a set beats a simultaneous clear
`timescale 1ns/1ps
`default_nettype none

module scirq_flag
	import scirq_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic set_in,
	input  wire logic clr_in,
	output var  logic flag_out
);

	// hold until cleared, set wins over clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flag_out <= 1'b0;
		else if (set_in)
			flag_out <= 1'b1;
		else if (clr_in)
			flag_out <= 1'b0;
	end

endmodule // scirq_flag

`default_nettype wire

// ### scirq_top.sv
// card interface select, uart bypass and interrupt cause collection
// Functional notes
// R1 - select field routes uart: 00 none, 01 external, 1X internal
// R2 - writing select changes routing only, never starts activation
// R3 - bypass set drives the line from line control registers
// R4 - reading cause register clears bits, except flags with own clear
// R5 - wait timeout flag; in sync mode set by length counter done
// R6 - card event flag on detect pin insert, removal or fault
// R7 - supply timer flag set on expiry, cleared by cause read
// R8 - rx available follows fifo occupancy, not cleared by read
// R9 - in bypass rx available sets on falling edge of line
// R10 - firmware should mask rx available in bypass until byte done
// R11 - tx event on tx empty or full rising, cleared by tx read
// R12 - tx sent after each byte, also crc or lrc in block mode
// R13 - character mode with break detect: no tx sent on break
// R14 - tx error on break or underrun, cleared by tx control read
// R15 - rx error on overrun or parity, cleared by rx control read
// R16 - enable bit one lets its cause interrupt, zero blocks it
// R17 - disabled causes still set their cause bits
// R18 - enable bits share bit positions with their causes
// R19 - interrupt is or of cause and enable pairs
`timescale 1ns/1ps
`default_nettype none
`include "scirq_regs.svh"

module scirq_top
	import scirq_pkg::*;
(
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [`SCIRQ_ADDR_W-1:0]  paddr,
	input  wire logic [31:0]               pwdata,
	output var  logic [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic                      uart_tx_data,
	input  wire logic                      uart_tx_oe,
	input  wire logic                      uart_clock,
	output var  logic                      uart_rx_data,
	output var  logic                      int_card_line_out,
	output var  logic                      int_card_line_oe,
	input  wire logic                      int_card_line_in,
	output var  logic                      int_card_clock,
	output var  logic                      ext_card_line_out,
	output var  logic                      ext_card_line_oe,
	input  wire logic                      ext_card_line_in,
	output var  logic                      ext_card_clock,
	input  wire logic                      sync_mode,
	input  wire logic                      wait_timeout_evt,
	input  wire logic                      length_done_flag,
	input  wire logic                      card_detect_pin,
	input  wire logic                      iface_fault,
	input  wire logic                      supply_timer_evt,
	input  wire logic                      rx_fifo_not_empty,
	input  wire logic                      tx_empty_flag,
	input  wire logic                      tx_full_indicator,
	input  wire logic                      break_detected_flag,
	input  wire logic                      tx_underrun_flag,
	input  wire logic                      rx_overrun_flag,
	input  wire logic                      rx_parity_err,
	input  wire logic                      tx_byte_done,
	input  wire logic                      crc_byte_done,
	input  wire logic                      block_mode,
	input  wire logic                      break_detect_en,
	input  wire logic                      break_at_byte_end,
	output var  logic                      card_irq
);

	////////////////////////////////////////////////////////////////////////
	// register state

	scirq_byte_type  select_reg;
	scirq_byte_type  enable_reg;
	scirq_byte_type  int_line_reg;
	scirq_byte_type  ext_line_reg;
	scirq_byte_type  captured_reg;
	scirq_byte_type  cause;
	scirq_iface_type interface_select;
	logic            bypass;
	logic            iface_active;
	logic            sel_line_in;
	logic            line_prev_reg;
	logic            card_prev_reg;
	logic            fault_prev_reg;
	logic            tx_empty_prev_reg;
	logic            tx_full_prev_reg;
	logic            brk_prev_reg;
	logic            undr_prev_reg;
	logic            ovr_prev_reg;
	logic            par_prev_reg;
	logic            rx_avail_reg;

	////////////////////////////////////////////////////////////////////////
	// apb decode

	logic                     setup_phase;
	logic                     access_phase;
	logic                     wr_en;
	logic                     rd_done;
	logic                     hit_select;
	logic                     hit_cause;
	logic                     hit_enable;
	logic                     hit_int_line;
	logic                     hit_ext_line;
	logic                     hit_tx_ctrl;
	logic                     hit_rx_ctrl;
	logic                     mapped;
	scirq_byte_type           rd_value;
	logic                     cause_read;
	logic                     tx_ctrl_read;
	logic                     rx_ctrl_read;

	// transfer phases; every access takes one access cycle
	assign setup_phase  = psel & ~penable;
	assign access_phase = psel & penable;
	assign pready       = access_phase;

	// address decode against byte addresses
	always_comb
	begin
		hit_select   = 1'b0;
		hit_cause    = 1'b0;
		hit_enable   = 1'b0;
		hit_int_line = 1'b0;
		hit_ext_line = 1'b0;
		hit_tx_ctrl  = 1'b0;
		hit_rx_ctrl  = 1'b0;
		if (paddr == `SCIRQ_BYTE(`SCIRQ_IDX_SELECT))
			hit_select = 1'b1;
		else if (paddr == `SCIRQ_BYTE(`SCIRQ_IDX_CAUSE))
			hit_cause = 1'b1;
		else if (paddr == `SCIRQ_BYTE(`SCIRQ_IDX_ENABLE))
			hit_enable = 1'b1;
		else if (paddr == `SCIRQ_BYTE(`SCIRQ_IDX_INT_LINE))
			hit_int_line = 1'b1;
		else if (paddr == `SCIRQ_BYTE(`SCIRQ_IDX_EXT_LINE))
			hit_ext_line = 1'b1;
		else if (paddr == `SCIRQ_BYTE(`SCIRQ_IDX_TX_CTRL))
			hit_tx_ctrl = 1'b1;
		else if (paddr == `SCIRQ_BYTE(`SCIRQ_IDX_RX_CTRL))
			hit_rx_ctrl = 1'b1;
	end

	assign mapped = hit_select | hit_cause | hit_enable | hit_int_line |
		hit_ext_line | hit_tx_ctrl | hit_rx_ctrl;
	assign pslverr = access_phase & ~mapped;
	assign wr_en   = access_phase & pwrite & mapped;
	assign rd_done = access_phase & ~pwrite;

	// read side effects happen at the completing edge
	assign cause_read   = rd_done & hit_cause;
	assign tx_ctrl_read = rd_done & hit_tx_ctrl;
	assign rx_ctrl_read = rd_done & hit_rx_ctrl;

	// read value of the addressed register
	always_comb
	begin
		rd_value = 8'h00;
		if (hit_select)
			rd_value = select_reg;
		else if (hit_cause)
			rd_value = cause;
		else if (hit_enable)
			rd_value = enable_reg;
		else if (hit_int_line)
			rd_value = {2'b00, int_card_line_in, 3'b000, int_line_reg[1:0]};
		else if (hit_ext_line)
			rd_value = {2'b00, ext_card_line_in, 3'b000, ext_line_reg[1:0]};
		else if (hit_tx_ctrl)
			rd_value = {4'h0, tx_underrun_flag, break_detected_flag,
				tx_full_indicator, tx_empty_flag};
		else if (hit_rx_ctrl)
			rd_value = {6'h00, rx_parity_err, rx_overrun_flag};
	end

	// read data captured in the setup cycle, held through access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (setup_phase && !pwrite)
			prdata <= {24'h00_0000, rd_value};
	end

	// snapshot of the cause bits that the current read reports
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			captured_reg <= 8'h00;
		else if (setup_phase)
			captured_reg <= (hit_cause && !pwrite) ? cause : 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// writable registers

	// select register; routing only, no activation side effect
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			select_reg <= `SCIRQ_SEL_RESET;
		else if (wr_en && hit_select)
			select_reg <= pwdata[7:0] & `SCIRQ_SEL_WMASK; // R2
	end

	// enable register, bits aligned with the cause bits
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			enable_reg <= `SCIRQ_ENABLE_RESET;
		else if (wr_en && hit_enable)
			enable_reg <= pwdata[7:0]; // R18
	end

	// line control registers for bypass drive
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			int_line_reg <= `SCIRQ_LINE_RESET;
			ext_line_reg <= `SCIRQ_LINE_RESET;
		end
		else if (wr_en && hit_int_line)
			int_line_reg <= pwdata[7:0] & `SCIRQ_LINE_WMASK;
		else if (wr_en && hit_ext_line)
			ext_line_reg <= pwdata[7:0] & `SCIRQ_LINE_WMASK;
	end

	////////////////////////////////////////////////////////////////////////
	// card line routing

	assign interface_select = scirq_iface_type'(select_reg[
		`SCIRQ_SEL_IFACE_HI:`SCIRQ_SEL_IFACE_LO]);
	assign bypass       = select_reg[`SCIRQ_SEL_BYPASS];
	assign iface_active = (interface_select != SCIRQ_IF_NONE);

	// uart or line registers drive the selected interface only
	always_comb
	begin
		int_card_line_out = 1'b1;
		int_card_line_oe  = 1'b0;
		int_card_clock    = 1'b0;
		ext_card_line_out = 1'b1;
		ext_card_line_oe  = 1'b0;
		ext_card_clock    = 1'b0;
		sel_line_in       = 1'b1;
		case (interface_select)
			SCIRQ_IF_EXT:
			begin
				sel_line_in    = ext_card_line_in; // R1
				ext_card_clock = uart_clock; // R1
				if (bypass)
				begin
					ext_card_line_out = ext_line_reg[`SCIRQ_LINE_DATA]; // R3
					ext_card_line_oe  = ext_line_reg[`SCIRQ_LINE_DIR]; // R3
				end
				else
				begin
					ext_card_line_out = uart_tx_data;
					ext_card_line_oe  = uart_tx_oe;
				end
			end
			SCIRQ_IF_INT, SCIRQ_IF_INT2:
			begin
				sel_line_in    = int_card_line_in; // R1
				int_card_clock = uart_clock;
				if (bypass)
				begin
					int_card_line_out = int_line_reg[`SCIRQ_LINE_DATA]; // R3
					int_card_line_oe  = int_line_reg[`SCIRQ_LINE_DIR]; // R3
				end
				else
				begin
					int_card_line_out = uart_tx_data;
					int_card_line_oe  = uart_tx_oe;
				end
			end
			default:
			begin
				sel_line_in = 1'b1; // R1
			end
		endcase
	end

	// uart receive sees an idle high line while bypassed
	assign uart_rx_data = bypass ? 1'b1 : sel_line_in; // R3

	////////////////////////////////////////////////////////////////////////
	// edge history for event detection

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			line_prev_reg     <= 1'b1;
			card_prev_reg     <= 1'b0;
			fault_prev_reg    <= 1'b0;
			tx_empty_prev_reg <= 1'b0;
			tx_full_prev_reg  <= 1'b0;
			brk_prev_reg      <= 1'b0;
			undr_prev_reg     <= 1'b0;
			ovr_prev_reg      <= 1'b0;
			par_prev_reg      <= 1'b0;
		end
		else
		begin
			line_prev_reg     <= sel_line_in;
			card_prev_reg     <= card_detect_pin;
			fault_prev_reg    <= iface_fault;
			tx_empty_prev_reg <= tx_empty_flag;
			tx_full_prev_reg  <= tx_full_indicator;
			brk_prev_reg      <= break_detected_flag;
			undr_prev_reg     <= tx_underrun_flag;
			ovr_prev_reg      <= rx_overrun_flag;
			par_prev_reg      <= rx_parity_err;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// cause flags

	logic set_wait;
	logic set_card;
	logic set_supply;
	logic set_tx_evt;
	logic set_tx_sent;
	logic set_tx_err;
	logic set_rx_err;
	logic line_fall;

	// uart causes count only while an interface is selected
	assign set_wait = iface_active & (sync_mode ? length_done_flag :
		wait_timeout_evt); // R5
	assign set_card = (card_detect_pin ^ card_prev_reg) |
		(iface_fault & ~fault_prev_reg); // R6
	assign set_supply = iface_active & supply_timer_evt; // R7
	assign set_tx_evt = iface_active &
		((tx_empty_flag & ~tx_empty_prev_reg) |
		(tx_full_indicator & ~tx_full_prev_reg)); // R11
	assign set_tx_sent = iface_active &
		((tx_byte_done & ~(~block_mode & break_detect_en &
		break_at_byte_end)) | // R13
		(block_mode & crc_byte_done)); // R12
	assign set_tx_err = iface_active &
		((break_detected_flag & ~brk_prev_reg) |
		(tx_underrun_flag & ~undr_prev_reg)); // R14
	assign set_rx_err = iface_active &
		((rx_overrun_flag & ~ovr_prev_reg) |
		(rx_parity_err & ~par_prev_reg)); // R15
	assign line_fall = iface_active & line_prev_reg & ~sel_line_in;

	// bits cleared by a cause read, only those that were reported
	scirq_flag u_wait
	(
		.pclk     (pclk),
		.presetn  (presetn),
		.set_in   (set_wait),
		.clr_in   (cause_read & captured_reg[`SCIRQ_B_WAIT_TO]), // R4
		.flag_out (cause[`SCIRQ_B_WAIT_TO])
	);

	scirq_flag u_card
	(
		.pclk     (pclk),
		.presetn  (presetn),
		.set_in   (set_card),
		.clr_in   (cause_read & captured_reg[`SCIRQ_B_CARD_EVT]), // R4
		.flag_out (cause[`SCIRQ_B_CARD_EVT])
	);

	scirq_flag u_supply
	(
		.pclk     (pclk),
		.presetn  (presetn),
		.set_in   (set_supply),
		.clr_in   (cause_read & captured_reg[`SCIRQ_B_SUPPLY_TMR]), // R7
		.flag_out (cause[`SCIRQ_B_SUPPLY_TMR])
	);

	scirq_flag u_tx_sent
	(
		.pclk     (pclk),
		.presetn  (presetn),
		.set_in   (set_tx_sent),
		.clr_in   (cause_read & captured_reg[`SCIRQ_B_TX_SENT]), // R4
		.flag_out (cause[`SCIRQ_B_TX_SENT])
	);

	// transmit flags clear on a transmit control read
	scirq_flag u_tx_evt
	(
		.pclk     (pclk),
		.presetn  (presetn),
		.set_in   (set_tx_evt),
		.clr_in   (tx_ctrl_read), // R11
		.flag_out (cause[`SCIRQ_B_TX_EVT])
	);

	scirq_flag u_tx_err
	(
		.pclk     (pclk),
		.presetn  (presetn),
		.set_in   (set_tx_err),
		.clr_in   (tx_ctrl_read), // R14
		.flag_out (cause[`SCIRQ_B_TX_ERR])
	);

	// receive error clears on a receive control read
	scirq_flag u_rx_err
	(
		.pclk     (pclk),
		.presetn  (presetn),
		.set_in   (set_rx_err),
		.clr_in   (rx_ctrl_read), // R15
		.flag_out (cause[`SCIRQ_B_RX_ERR])
	);

	// rx available: fifo level normally, line falling edge in bypass
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rx_avail_reg <= 1'b0;
		else if (bypass)
		begin
			if (line_fall)
				rx_avail_reg <= 1'b1; // R9
			else if (cause_read && captured_reg[`SCIRQ_B_RX_AVAIL])
				rx_avail_reg <= 1'b0;
		end
		else
			rx_avail_reg <= iface_active & rx_fifo_not_empty; // R8
	end

	assign cause[`SCIRQ_B_RX_AVAIL] = rx_avail_reg;

	////////////////////////////////////////////////////////////////////////
	// interrupt output

	// causes always latch; enables only gate the output
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			card_irq <= 1'b0;
		else
			card_irq <= |(cause & enable_reg); // R16 R17 R19
	end

endmodule // scirq_top

`default_nettype wire

// ### scirq_top_monitor.sv
// port checker of the card select and interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "scirq_regs.svh"

module scirq_top_monitor
	import scirq_pkg::*;
(
	input wire logic                     pclk,
	input wire logic                     presetn,
	input wire logic                     psel,
	input wire logic                     penable,
	input wire logic                     pwrite,
	input wire logic [`SCIRQ_ADDR_W-1:0] paddr,
	input wire logic [31:0]              pwdata,
	input wire logic [31:0]              prdata,
	input wire logic                     uart_clock,
	input wire logic                     uart_rx_data,
	input wire logic                     int_card_line_oe,
	input wire logic                     int_card_line_in,
	input wire logic                     int_card_clock,
	input wire logic                     ext_card_line_oe,
	input wire logic                     ext_card_line_in,
	input wire logic                     ext_card_clock,
	input wire logic                     card_detect_pin,
	input wire logic                     supply_timer_evt,
	input wire logic                     rx_fifo_not_empty,
	input wire logic                     card_irq
);
	localparam logic [17:0] A_SEL = `SCIRQ_BYTE(`SCIRQ_IDX_SELECT);
	localparam logic [17:0] A_EN = `SCIRQ_BYTE(`SCIRQ_IDX_ENABLE);
	logic       wr;
	logic [7:0] sel_reg;
	logic [7:0] en_reg;

	assign wr = psel && penable && pwrite;

	// shadow of the select register
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			sel_reg <= 8'h00;
		else if (wr && paddr == A_SEL)
			sel_reg <= pwdata[7:0] & `SCIRQ_SEL_WMASK;

	// shadow of the enable register
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			en_reg <= 8'h00;
		else if (wr && paddr == A_EN)
			en_reg <= pwdata[7:0];

	default clocking mon_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////////////////
	AST_NONE_IDLE:
	assert property (sel_reg[3:2] == 2'b00 |-> !int_card_line_oe &&
		!ext_card_line_oe && !int_card_clock && !ext_card_clock && uart_rx_data)
		else $error("card side active with no interface chosen");
	AST_EXT_ROUTE:
	assert property (sel_reg[3:1] == 3'b010 |-> ext_card_clock == uart_clock
		&& !int_card_clock && uart_rx_data == ext_card_line_in)
		else $error("external routing wrong");
	AST_INT_ROUTE:
	assert property (sel_reg[3] && !sel_reg[1] |-> int_card_clock ==
		uart_clock && !ext_card_clock && uart_rx_data == int_card_line_in)
		else $error("internal routing wrong");
	AST_BYPASS_RX:
	assert property (sel_reg[1] |-> uart_rx_data)
		else $error("uart receive not idle in bypass");
	AST_TMR_IRQ:
	assert property (supply_timer_evt && en_reg[5] && sel_reg[3:2] != 2'b00
		##1 en_reg[5] |=> card_irq)
		else $error("supply timer did not interrupt");
	AST_CARD_IRQ:
	assert property ($changed(card_detect_pin) && en_reg[6] ##1 en_reg[6]
		|=> card_irq)
		else $error("card event did not interrupt");
	AST_RXAV_IRQ:
	assert property ((rx_fifo_not_empty && en_reg[4] && sel_reg[3:2] != 2'b00
		&& !sel_reg[1])[*2] |=> card_irq)
		else $error("receive data did not interrupt");
	AST_EN0_QUIET:
	assert property ($past(en_reg) == 8'h00 |-> !card_irq)
		else $error("interrupt with every cause disabled");
	AST_UPPER_ZERO:
	assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");

endmodule // scirq_top_monitor
`default_nettype wire

// ### scirq_card_model.sv
// card end of one card line, with the line's pull-up
`timescale 1ns/1ps
`default_nettype none

module scirq_card_model
(
	input  wire logic dev_out,
	input  wire logic dev_oe,
	input  wire logic card_oe,
	input  wire logic card_val,
	output wire logic line_in
);
	// device wins while driving, then the card, else the pull-up
	assign line_in = dev_oe ? dev_out : (card_oe ? card_val : 1'b1);
endmodule // scirq_card_model
`default_nettype wire

// ### scirq_top_tb.sv
// self-checking bench of the card select and interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "scirq_regs.svh"

module scirq_top_tb;
	localparam logic [17:0] A_SEL = `SCIRQ_BYTE(`SCIRQ_IDX_SELECT);
	localparam logic [17:0] A_CAU = `SCIRQ_BYTE(`SCIRQ_IDX_CAUSE);
	localparam logic [17:0] A_EN  = `SCIRQ_BYTE(`SCIRQ_IDX_ENABLE);
	localparam logic [17:0] A_ILN = `SCIRQ_BYTE(`SCIRQ_IDX_INT_LINE);
	localparam logic [17:0] A_TX  = `SCIRQ_BYTE(`SCIRQ_IDX_TX_CTRL);
	localparam logic [17:0] A_RX  = `SCIRQ_BYTE(`SCIRQ_IDX_RX_CTRL);
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        uart_tx_data, uart_tx_oe, uart_clock, uart_rx_data;
	logic        int_card_line_out, int_card_line_oe, int_card_line_in;
	logic        ext_card_line_out, ext_card_line_oe, ext_card_line_in;
	logic        int_card_clock, ext_card_clock, card_irq, sync_mode;
	logic        wait_timeout_evt, length_done_flag, card_detect_pin;
	logic        iface_fault, supply_timer_evt, rx_fifo_not_empty;
	logic        tx_empty_flag, tx_full_indicator, break_detected_flag;
	logic        tx_underrun_flag, rx_overrun_flag, rx_parity_err;
	logic        tx_byte_done, crc_byte_done, block_mode;
	logic        break_detect_en, break_at_byte_end, int_val_card;
	logic [3:0]  cnt = 4'h0;
	logic [7:0]  m;
	logic [32:0] exp_q[$];
	int          n_mismatch, compares, i;

	scirq_top u_dut
	(
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .uart_tx_data, .uart_tx_oe, .uart_clock,
		.uart_rx_data, .int_card_line_out, .int_card_line_oe,
		.int_card_line_in, .int_card_clock, .ext_card_line_out,
		.ext_card_line_oe, .ext_card_line_in, .ext_card_clock, .sync_mode,
		.wait_timeout_evt, .length_done_flag, .card_detect_pin, .iface_fault,
		.supply_timer_evt, .rx_fifo_not_empty, .tx_empty_flag,
		.tx_full_indicator, .break_detected_flag, .tx_underrun_flag,
		.rx_overrun_flag, .rx_parity_err, .tx_byte_done, .crc_byte_done,
		.block_mode, .break_detect_en, .break_at_byte_end, .card_irq
	);

	// card ends: internal card follows the bench, external card holds low
	scirq_card_model u_icard (.dev_out(int_card_line_out),
		.dev_oe(int_card_line_oe), .card_oe(1'b1), .card_val(int_val_card),
		.line_in(int_card_line_in));
	scirq_card_model u_ecard (.dev_out(ext_card_line_out),
		.dev_oe(ext_card_line_oe), .card_oe(1'b1), .card_val(1'b0),
		.line_in(ext_card_line_in));

	// clock, and a slow uart clock and transmit pattern
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk)
		cnt <= cnt + 4'h1;
	assign uart_clock = cnt[0];
	assign uart_tx_data = cnt[2];
	assign uart_tx_oe = cnt[3];

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [32:0] e, input logic [32:0] g);
		compares++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic pin(input logic e, input logic g);
		chk({32'h0, e}, {32'h0, g});
	endtask
	// one apb transfer; a read notes {slverr, data} it expects
	task automatic apb(input logic w, input logic [17:0] a,
		input logic [31:0] d, input logic [32:0] e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w)
			exp_q.push_back(e);
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [17:0] a, input logic [7:0] e);
		apb(1'b0, a, 32'h0, {25'h0, e});
	endtask
	task automatic wr(input logic [17:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d}, 33'h0);
	endtask
	task automatic irq(input logic e);
		@(posedge pclk);
		@(negedge pclk);
		pin(e, card_irq);
	endtask
	// drives the source of cause bit b (8 crc sent, 9 length done)
	task automatic fire(input int b, input logic v);
		@(posedge pclk);
		case (b)
			9: length_done_flag <= v;
			8: crc_byte_done <= v;
			7: wait_timeout_evt <= v;
			6: card_detect_pin <= v;
			5: supply_timer_evt <= v;
			4: rx_fifo_not_empty <= v;
			3: tx_empty_flag <= v;
			2: tx_byte_done <= v;
			1: tx_underrun_flag <= v;
			default: rx_parity_err <= v;
		endcase
	endtask
	task automatic final_report;
		n_mismatch += exp_q.size();
		$display("compares=%0d mismatches=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// read results against the oldest note
	always @(posedge pclk)
		if (psel && penable && pready && !pwrite)
			chk(exp_q.pop_front(), {pslverr, prdata});

	initial
	begin
		repeat (5000) @(posedge pclk);
		n_mismatch++;
		final_report;
	end

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		n_mismatch = 0;
		compares = 0;
		int_val_card = 1'b0;
		{presetn, psel, penable, pwrite, paddr, pwdata, sync_mode,
			wait_timeout_evt, length_done_flag, card_detect_pin, iface_fault,
			supply_timer_evt, rx_fifo_not_empty, tx_empty_flag,
			tx_full_indicator, break_detected_flag, tx_underrun_flag,
			rx_overrun_flag, rx_parity_err, tx_byte_done, crc_byte_done,
			block_mode, break_detect_en, break_at_byte_end} = '0;
		void'($urandom(32'hA601D87D));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd(A_SEL, 8'h00);
		rd(A_CAU, 8'h00);
		rd(A_EN, 8'h00);
		apb(1'b0, 18'h3FFF0, 32'h0, {1'b1, 32'h0});
		$display("reset values done");
		m = 8'($urandom);
		wr(A_EN, m);
		rd(A_EN, m);
		wr(A_SEL, ~m);
		rd(A_SEL, ~m & `SCIRQ_SEL_WMASK);
		$display("register access done");
		for (i = 0; i < 4; i++)
		begin
			wr(A_SEL, {4'h0, i[1:0], 2'b00});
			rd(A_SEL, {4'h0, i[1:0], 2'b00});
			@(negedge pclk);
			pin(i[1] ? uart_clock : 1'b0, int_card_clock);
			pin(i == 1 ? uart_clock : 1'b0, ext_card_clock);
			pin(i == 1 ? uart_tx_data : 1'b1,
				ext_card_line_out);
			pin(i == 0 ? 1'b1 : (i == 1 ? ext_card_line_in :
				int_card_line_in), uart_rx_data);
		end
		$display("routing done");
		wr(A_SEL, 8'h08);
		for (i = 0; i < 8; i++)
		begin
			m = 8'h01 << i;
			wr(A_EN, m);
			fire(i, 1'b1);
			if ((m & 8'h1B) == 8'h00)
				fire(i, 1'b0);
			@(posedge pclk);
			irq(1'b1);
			rd(A_CAU, m);
			if ((m & 8'h1B) != 8'h00)
			begin
				rd(A_CAU, m);
				fire(i, 1'b0);
				if (i == 3 || i == 1)
					rd(A_TX, 8'h00);
				if (i == 0)
					rd(A_RX, 8'h00);
				repeat (2) @(posedge pclk);
			end
			rd(A_CAU, 8'h00);
			irq(1'b0);
		end
		$display("interrupt causes done");
		wr(A_EN, 8'h00);
		fire(5, 1'b1);
		fire(5, 1'b0);
		@(posedge pclk);
		irq(1'b0);
		rd(A_CAU, 8'h20);
		$display("masked cause done");
		break_detect_en <= 1'b1;
		break_at_byte_end <= 1'b1;
		fire(2, 1'b1);
		fire(2, 1'b0);
		rd(A_CAU, 8'h00);
		block_mode <= 1'b1;
		fire(8, 1'b1);
		fire(8, 1'b0);
		rd(A_CAU, 8'h04);
		sync_mode <= 1'b1;
		fire(9, 1'b1);
		fire(9, 1'b0);
		rd(A_CAU, 8'h80);
		$display("transmit and sync causes done");
		int_val_card <= 1'b1;
		wr(A_SEL, 8'h0A);
		wr(A_EN, 8'h10);
		@(posedge pclk);
		int_val_card <= 1'b0;
		@(posedge pclk);
		irq(1'b1);
		wr(A_EN, 8'h00);
		rd(A_CAU, 8'h10);
		rd(A_CAU, 8'h00);
		wr(A_ILN, 8'h02);
		@(negedge pclk);
		pin(1'b1, int_card_line_oe);
		pin(1'b0, int_card_line_out);
		$display("bypass done");
		final_report;
	end
endmodule // scirq_top_tb

bind scirq_top scirq_top_monitor u_mon
(
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.uart_clock, .uart_rx_data, .int_card_line_oe, .int_card_line_in,
	.int_card_clock, .ext_card_line_oe, .ext_card_line_in, .ext_card_clock,
	.card_detect_pin, .supply_timer_evt, .rx_fifo_not_empty, .card_irq
);
`default_nettype wire
